// >>> cpm_consts.svh
// Offsets, field positions, reset values and timing counts of the protection controller
`ifndef CPM_CONSTS_SVH
`define CPM_CONSTS_SVH

`define CPM_ADDR_W 12
`define CPM_OFS_CTRL 12'h000
`define CPM_OFS_STATUS 12'h004
`define CPM_OFS_FAULTS 12'h008
`define CPM_OFS_DUTY 12'h00C

`define CPM_CTRL_HOLD 0
`define CPM_CTRL_RESET 32'h0000_0000

`define CPM_ST_MODE_LSB 0
`define CPM_ST_GOOD 4
`define CPM_ST_OPEN 5
`define CPM_ST_SHORT 6
`define CPM_ST_AUTORST 7
`define CPM_ST_ACTLOW 8
`define CPM_ST_PGPIN 9

`define CPM_FLT_FB_OV 0
`define CPM_FLT_FAILSAFE 1
`define CPM_FLT_OVERTEMP 2
`define CPM_FLT_UNDERV 3
`define CPM_FLT_PIN_OPEN 4
`define CPM_FLT_PIN_SHORT 5
`define CPM_FLT_LOCKOUT 6
`define CPM_FLT_W 7

`define CPM_CLK_NS 50
`define CPM_OPEN_PIN_NS 2900
`define CPM_OPEN_PIN_CYC ((`CPM_OPEN_PIN_NS) / (`CPM_CLK_NS))
`define CPM_RESTART_CYC 20000
`define CPM_SS_STEP_CYC 16
`define CPM_DUTY_MAX 8'hFF

`endif

// >>> cpm_pkg.sv
// Types shared by the protection controller modules
package cpm_pkg;

   typedef enum logic [2:0] {
      mode_disable,
      mode_soft,
      mode_normal,
      mode_lockout,
      mode_latched,
      mode_retry
   } cpm_mode_e;

   typedef struct packed {
      logic supply_uvlo;
      logic supply_ovlo;
      logic supply_low_fall_limit;
      logic turn_on_request;
      logic pos_feedback_over_limit;
      logic neg_feedback_over_limit;
      logic pos_failsafe_limit;
      logic neg_failsafe_limit;
      logic pri_overtemp;
      logic sec_overtemp;
      logic pos_fb_low;
      logic neg_fb_low;
      logic pos_rail_start_level;
      logic inverter_peak_limit;
      logic inverter_blank_end;
      logic inverter_blank_over;
      logic good_pin;
      logic cfg_auto_restart;
      logic cfg_good_active_low;
   } cpm_flags_s;

   typedef struct packed {
      cpm_mode_e mode;
      logic auto_restart;
      logic active_low;
      logic hold;
      logic [6:0] faults;
      logic pin_open;
      logic pin_short;
      logic start_prev;
      logic blank_prev;
      logic width_run;
      logic width_done;
      logic [7:0] width_cnt;
      logic [7:0] duty;
      logic prim_en;
      logic bb_en;
      logic good;
      logic [31:0] prdata;
      logic pslverr;
   } cpm_state_s;

endpackage

// >>> cpm_flags_if.sv
// Synchronised condition flags passed from the synchroniser to the controller
`timescale 1ns/10ps
`default_nettype none
interface cpm_flags_if;
   cpm_pkg::cpm_flags_s val;
   modport src (output val);
   modport dst (input val);
endinterface
`default_nettype wire

// >>> cpm_sync.sv
// Two-stage synchroniser for all asynchronous condition inputs
`timescale 1ns/10ps
`default_nettype none
module cpm_sync (
   input wire logic core_clk,
   input wire cpm_pkg::cpm_flags_s raw,
   cpm_flags_if.src flags
);
   import cpm_pkg::*;

   typedef struct packed {
      cpm_flags_s meta;
      cpm_flags_s sync;
   } cpm_sync_s;

   cpm_sync_s st_q;
   cpm_sync_s st_d;

   // No reset: straps must pass through while reset is held
   always_comb begin
      st_d.meta = raw;
      st_d.sync = st_q.meta;
   end

   always_ff @(posedge core_clk) begin
      st_q <= st_d;
   end

   assign flags.val = st_q.sync;
endmodule
`default_nettype wire

// >>> cpm_timer.sv
// Loadable down-counter giving a one-cycle pulse when it runs out
`timescale 1ns/10ps
`default_nettype none
module cpm_timer #(
   parameter int W = 16
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic load,
   input wire logic [W-1:0] value,
   output logic done
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic armed;
   } cpm_tmr_s;

   cpm_tmr_s st_q;
   cpm_tmr_s st_d;

   always_comb begin
      st_d = st_q;
      if (!reset_n) begin
         st_d = '0;
      end else if (load) begin
         st_d.cnt = value;
         st_d.armed = 1'b1;
      end else if (st_q.armed && st_q.cnt != '0) begin
         st_d.cnt = st_q.cnt - 1'b1;
      end else begin
         st_d.armed = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      st_q <= st_d;
   end

   // Not gated by load: the user reloads on done, which would close a loop
   assign done = st_q.armed && (st_q.cnt == '0);
endmodule
`default_nettype wire

// >>> cpm_protect_fsm.sv
// Protection and operating-mode controller for an isolated dual-output converter
`timescale 1ns/10ps
`default_nettype none
`include "cpm_consts.svh"
module cpm_protect_fsm #(
   parameter int RESTART_CYC = `CPM_RESTART_CYC,
   parameter int SS_STEP_CYC = `CPM_SS_STEP_CYC,
   parameter int OPEN_PIN_CYC = `CPM_OPEN_PIN_CYC
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`CPM_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic turn_on_request,
   input wire logic supply_uvlo,
   input wire logic supply_ovlo,
   input wire logic supply_low_fall_limit,
   input wire logic pos_feedback_over_limit,
   input wire logic neg_feedback_over_limit,
   input wire logic pos_failsafe_limit,
   input wire logic neg_failsafe_limit,
   input wire logic pri_overtemp,
   input wire logic sec_overtemp,
   input wire logic pos_fb_low,
   input wire logic neg_fb_low,
   input wire logic pos_rail_start_level,
   input wire logic inverter_peak_limit,
   input wire logic inverter_blank_end,
   input wire logic inverter_blank_over,
   input wire logic cfg_auto_restart,
   input wire logic cfg_good_active_low,
   input wire logic output_good_flag_i,
   output logic output_good_flag_o,
   output logic output_good_flag_oe,
   output logic primary_switch_en,
   output logic buckboost_switch_en,
   output logic [7:0] primary_duty,
   output logic [2:0] mode_code
);
   import cpm_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Address decode for the error answer; read data decodes paddr in its own case

   function automatic logic cpm_mapped(input logic [`CPM_ADDR_W-1:0] a);
      cpm_mapped = (a == `CPM_OFS_CTRL) || (a == `CPM_OFS_STATUS) ||
                   (a == `CPM_OFS_FAULTS) || (a == `CPM_OFS_DUTY);
   endfunction

   localparam logic [31:0] CTRL_RST = `CPM_CTRL_RESET;

   function automatic logic cpm_is_on(input cpm_mode_e m);
      cpm_is_on = (m == mode_soft) || (m == mode_normal);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Input synchronisation

   cpm_flags_if flags_if ();
   cpm_flags_s raw;
   cpm_flags_s f;

   always_comb begin
      raw.supply_uvlo = supply_uvlo;
      raw.supply_ovlo = supply_ovlo;
      raw.supply_low_fall_limit = supply_low_fall_limit;
      raw.turn_on_request = turn_on_request;
      raw.pos_feedback_over_limit = pos_feedback_over_limit;
      raw.neg_feedback_over_limit = neg_feedback_over_limit;
      raw.pos_failsafe_limit = pos_failsafe_limit;
      raw.neg_failsafe_limit = neg_failsafe_limit;
      raw.pri_overtemp = pri_overtemp;
      raw.sec_overtemp = sec_overtemp;
      raw.pos_fb_low = pos_fb_low;
      raw.neg_fb_low = neg_fb_low;
      raw.pos_rail_start_level = pos_rail_start_level;
      raw.inverter_peak_limit = inverter_peak_limit;
      raw.inverter_blank_end = inverter_blank_end;
      raw.inverter_blank_over = inverter_blank_over;
      raw.good_pin = output_good_flag_i;
      raw.cfg_auto_restart = cfg_auto_restart;
      raw.cfg_good_active_low = cfg_good_active_low;
   end

   cpm_sync u_sync (
      .core_clk(core_clk),
      .raw(raw),
      .flags(flags_if.src)
   );

   assign f = flags_if.val;

   ////////////////////////////////////////////////////////////////////////////////
   // Timers for duty steps and retry wait

   cpm_state_s st_q;
   cpm_state_s st_d;
   logic step_load;
   logic step_done;
   logic retry_load;
   logic retry_done;

   cpm_timer #(.W(16)) u_step (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .load(step_load),
      .value(16'(SS_STEP_CYC - 1)),
      .done(step_done)
   );

   cpm_timer #(.W(32)) u_retry (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .load(retry_load),
      .value(32'(RESTART_CYC - 1)),
      .done(retry_done)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Next-state logic

   logic req;
   logic lockout;
   logic ss_done;
   logic pin_fault;
   logic trip_fb_ov;
   logic trip_failsafe;
   logic trip_temp;
   logic trip_uv;
   logic trip_pin;
   logic trip;
   logic setup;
   logic wr;
   logic [`CPM_FLT_W-1:0] flt_set;
   logic [`CPM_FLT_W-1:0] flt_clr;
   logic blank_rise;
   logic start_rise;

   always_comb begin
      st_d = st_q;
      step_load = 1'b0;
      retry_load = 1'b0;

      // Undriven request reads low through the pull-down
      req = f.turn_on_request && !st_q.hold;
      lockout = f.supply_uvlo || f.supply_ovlo;
      ss_done = (st_q.mode == mode_soft) && (st_q.duty == `CPM_DUTY_MAX);
      pin_fault = st_q.pin_open || st_q.pin_short;

      trip_fb_ov = (st_q.mode == mode_normal) &&
                   (f.pos_feedback_over_limit || f.neg_feedback_over_limit);
      trip_failsafe = cpm_is_on(st_q.mode) &&
                      (f.pos_failsafe_limit || f.neg_failsafe_limit);
      trip_temp = cpm_is_on(st_q.mode) && (f.pri_overtemp || f.sec_overtemp);
      trip_uv = ((st_q.mode == mode_normal) || ss_done) &&
                (f.pos_fb_low || f.neg_fb_low);
      trip_pin = ss_done && pin_fault;
      trip = trip_fb_ov || trip_failsafe || trip_temp || trip_uv || trip_pin;

      // Switch-pin checks, soft start only
      start_rise = f.pos_rail_start_level && !st_q.start_prev;
      blank_rise = f.inverter_blank_end && !st_q.blank_prev;
      st_d.start_prev = f.pos_rail_start_level;
      st_d.blank_prev = f.inverter_blank_end;
      if (st_q.mode == mode_soft) begin
         if (start_rise && !st_q.width_done) begin
            st_d.width_run = 1'b1;
            st_d.width_done = 1'b1;
            st_d.width_cnt = '0;
         end else if (st_q.width_run) begin
            if (f.inverter_peak_limit) begin
               st_d.width_run = 1'b0;
            end else if (st_q.width_cnt >= 8'(OPEN_PIN_CYC)) begin
               st_d.pin_open = 1'b1;
               st_d.width_run = 1'b0;
            end else begin
               st_d.width_cnt = st_q.width_cnt + 8'h01;
            end
         end
         if (blank_rise && f.inverter_blank_over) begin
            st_d.pin_short = 1'b1;
         end
      end else begin
         st_d.width_run = 1'b0;
      end

      // Duty ramp
      if ((st_q.mode == mode_soft) && step_done && !ss_done) begin
         st_d.duty = st_q.duty + 8'h01;
         step_load = 1'b1;
      end

      // Mode transitions
      case (st_q.mode)
         mode_disable: begin
            if (lockout) begin
               st_d.mode = mode_lockout;
            end else if (req) begin
               st_d.mode = mode_soft;
            end
         end
         mode_soft, mode_normal: begin
            if (lockout) begin
               st_d.mode = mode_lockout;
            end else if (trip) begin
               if (st_q.auto_restart) begin
                  st_d.mode = mode_retry;
                  retry_load = 1'b1;
               end else begin
                  st_d.mode = mode_latched;
               end
            end else if (!req) begin
               st_d.mode = mode_disable;
            end else if (ss_done) begin
               st_d.mode = mode_normal;
            end
         end
         mode_lockout: begin
            if (!lockout) begin
               st_d.mode = req ? mode_soft : mode_disable;
            end
         end
         mode_latched: begin
            // Undervoltage or overvoltage lockout alone leaves the latch in place
            if (f.supply_low_fall_limit) begin
               st_d.mode = mode_lockout;
            end else if (!req) begin
               st_d.mode = mode_disable;
            end
         end
         mode_retry: begin
            if (lockout) begin
               st_d.mode = mode_lockout;
            end else if (!req) begin
               st_d.mode = mode_disable;
            end else if (retry_done) begin
               st_d.mode = mode_soft;
            end
         end
         default: begin
            st_d.mode = mode_disable;
         end
      endcase

      // Fresh soft start clears ramp and pin checks
      if ((st_d.mode == mode_soft) && (st_q.mode != mode_soft)) begin
         st_d.duty = '0;
         st_d.pin_open = 1'b0;
         st_d.pin_short = 1'b0;
         st_d.width_done = 1'b0;
         st_d.width_run = 1'b0;
         step_load = 1'b1;
      end

      // Registered outputs follow the next mode
      st_d.prim_en = cpm_is_on(st_d.mode);
      st_d.bb_en = cpm_is_on(st_d.mode) && !st_d.pin_open && !st_d.pin_short;
      st_d.good = (st_d.mode == mode_normal);

      // Register bus
      setup = psel && !penable;
      wr = psel && penable && pwrite;
      flt_set = '0;
      flt_set[`CPM_FLT_FB_OV] = trip_fb_ov;
      flt_set[`CPM_FLT_FAILSAFE] = trip_failsafe;
      flt_set[`CPM_FLT_OVERTEMP] = trip_temp;
      flt_set[`CPM_FLT_UNDERV] = trip_uv;
      flt_set[`CPM_FLT_PIN_OPEN] = st_d.pin_open && !st_q.pin_open;
      flt_set[`CPM_FLT_PIN_SHORT] = st_d.pin_short && !st_q.pin_short;
      flt_set[`CPM_FLT_LOCKOUT] = lockout;
      flt_clr = '0;
      if (wr && (paddr == `CPM_OFS_FAULTS)) begin
         flt_clr = pwdata[`CPM_FLT_W-1:0];
      end
      // New events win over a clear in the same cycle
      st_d.faults = (st_q.faults & ~flt_clr) | flt_set;
      if (wr && (paddr == `CPM_OFS_CTRL)) begin
         st_d.hold = pwdata[`CPM_CTRL_HOLD];
      end
      if (setup) begin
         st_d.prdata = '0;
         st_d.pslverr = !cpm_mapped(paddr);
         case (paddr)
            `CPM_OFS_CTRL: begin
               st_d.prdata[`CPM_CTRL_HOLD] = st_q.hold;
            end
            `CPM_OFS_STATUS: begin
               st_d.prdata[`CPM_ST_MODE_LSB +: 3] = st_q.mode;
               st_d.prdata[`CPM_ST_GOOD] = st_q.good;
               st_d.prdata[`CPM_ST_OPEN] = st_q.pin_open;
               st_d.prdata[`CPM_ST_SHORT] = st_q.pin_short;
               st_d.prdata[`CPM_ST_AUTORST] = st_q.auto_restart;
               st_d.prdata[`CPM_ST_ACTLOW] = st_q.active_low;
               st_d.prdata[`CPM_ST_PGPIN] = f.good_pin;
            end
            `CPM_OFS_FAULTS: begin
               st_d.prdata[`CPM_FLT_W-1:0] = st_q.faults;
            end
            `CPM_OFS_DUTY: begin
               st_d.prdata[7:0] = st_q.duty;
            end
            default: begin
               st_d.prdata = '0;
            end
         endcase
      end

      // Synchronous reset also captures the variant straps
      if (!reset_n) begin
         st_d = '0;
         st_d.mode = mode_disable;
         st_d.hold = CTRL_RST[`CPM_CTRL_HOLD];
         st_d.auto_restart = f.cfg_auto_restart;
         st_d.active_low = f.cfg_good_active_low;
         step_load = 1'b0;
         retry_load = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      st_q <= st_d;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign prdata = st_q.prdata;
   assign pslverr = st_q.pslverr;
   assign pready = 1'b1;
   assign primary_switch_en = st_q.prim_en;
   assign buckboost_switch_en = st_q.bb_en;
   assign primary_duty = st_q.duty;
   assign mode_code = st_q.mode;

   // Open drain: only ever pulls low
   assign output_good_flag_o = 1'b0;
   assign output_good_flag_oe = st_q.active_low ? st_q.good : !st_q.good;

endmodule
`default_nettype wire

// >>> cpm_protect_checker.sv
// Concurrent checks on the protection controller ports
`timescale 1ns/10ps
`default_nettype none
`include "cpm_consts.svh"
module cpm_protect_checker #(
   parameter int RESTART_CYC = 50
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic [`CPM_ADDR_W-1:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic turn_on_request,
   input wire logic supply_low_fall_limit,
   input wire logic pos_feedback_over_limit,
   input wire logic neg_feedback_over_limit,
   input wire logic pos_failsafe_limit,
   input wire logic neg_failsafe_limit,
   input wire logic pri_overtemp,
   input wire logic sec_overtemp,
   input wire logic cfg_good_active_low,
   input wire logic output_good_flag_oe,
   input wire logic primary_switch_en,
   input wire logic buckboost_switch_en,
   input wire logic [7:0] primary_duty,
   input wire logic [2:0] mode_code
);
   int rcnt;
   logic good_act;
   assign good_act = output_good_flag_oe == cfg_good_active_low;
   // Cycles spent waiting in retry
   always_ff @(posedge core_clk) begin
      if (!reset_n || mode_code != 3'h5) begin
         rcnt <= 0;
      end else begin
         rcnt <= rcnt + 1;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////////////////////////
   a_fbov_stop: assert property (((pos_feedback_over_limit || neg_feedback_over_limit)
      && mode_code == 3'h2) [*3] |=> !primary_switch_en && mode_code != 3'h2)
      else $error("feedback overvoltage did not stop switching");
   a_failsafe_stop: assert property (((pos_failsafe_limit || neg_failsafe_limit)
      && (mode_code == 3'h1 || mode_code == 3'h2)) [*3] |=> !primary_switch_en
      && !buckboost_switch_en) else $error("fail-safe overvoltage did not shut down");
   a_temp_stop: assert property (((pri_overtemp || sec_overtemp)
      && (mode_code == 3'h1 || mode_code == 3'h2)) [*3] |=> !primary_switch_en && !good_act)
      else $error("over-temperature did not stop switching");
   a_pin_soft: assert property ($fell(buckboost_switch_en) && primary_switch_en
      |-> mode_code == 3'h1) else $error("switch-pin fault outside soft start");
   a_disable_off: assert property (mode_code == 3'h0
      |-> !primary_switch_en && !buckboost_switch_en) else $error("switching in disable");
   a_soft_ramp: assert property (mode_code == 3'h1 && $past(mode_code) == 3'h1
      |-> primary_duty == $past(primary_duty) || primary_duty == $past(primary_duty) + 8'h01)
      else $error("duty stepped too fast");
   a_latch_hold: assert property ((mode_code == 3'h4 && turn_on_request
      && !supply_low_fall_limit) [*4] |=> mode_code == 3'h4) else $error("latch released");
   a_retry_wait: assert property (mode_code == 3'h1 && $past(mode_code) == 3'h5
      |-> rcnt >= RESTART_CYC - 2 && rcnt <= RESTART_CYC + 3) else $error("retry time off");
   a_fault_off: assert property (mode_code >= 3'h3
      |-> !primary_switch_en && !buckboost_switch_en && !good_act) else $error("on in fault");
   a_good_mode: assert property (good_act |-> mode_code == 3'h2)
      else $error("good active outside normal");
   a_apb_resp: assert property (psel && penable && paddr[1:0] == 2'h0
      |-> pready && pslverr == (paddr > 12'h00C)) else $error("bad bus response");
   c_normal: cover property (mode_code == 3'h2 && good_act);
   c_latched: cover property (mode_code == 3'h4);
   c_retry: cover property (mode_code == 3'h5 ##1 mode_code == 3'h1);
   c_lockout: cover property (mode_code == 3'h3);
endmodule
`default_nettype wire

// >>> cpm_host_model.sv
// Host side: drives the turn-on request and resolves the open-drain good pad
`timescale 1ns/10ps
`default_nettype none
module cpm_host_model (
   input wire logic drive_en,
   input wire logic drive_val,
   input wire logic good_o,
   input wire logic good_oe,
   output logic turn_on_request,
   output logic good_pad
);
   // Released request reads low
   assign turn_on_request = drive_en ? drive_val : 1'b0;
   // Pull-up on the pad
   assign good_pad = good_oe ? good_o : 1'b1;
endmodule
`default_nettype wire

// >>> cpm_protect_fsm_test.sv
// Self-checking bench for the protection and mode controller
`timescale 1ns/10ps
`default_nettype none
`include "cpm_consts.svh"
module cpm_protect_fsm_test;
   import cpm_pkg::*;
   localparam logic [14:0] C_UV = 15'h0001, C_OV = 15'h0002, C_LF = 15'h0004;
   localparam logic [14:0] C_FBOV = 15'h0008, C_FS = 15'h0020, C_OT = 15'h0080;
   localparam logic [14:0] C_OT2 = 15'h0100, C_UVFB = 15'h0200, C_START = 15'h0800;
   localparam logic [14:0] C_BEND = 15'h2000, C_BOVER = 15'h4000;
   logic core_clk, reset_n, psel, penable, pwrite, pready, pslverr, err, req, drv_en, drv_val;
   logic cfg_ar, cfg_al, pad, g_o, g_oe, pri_en, bb_en;
   logic [`CPM_ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [14:0] c;
   logic [7:0] duty;
   logic [2:0] mode;
   int fails, checks;
   cpm_protect_fsm #(.RESTART_CYC(50), .SS_STEP_CYC(1)) i_cpm_protect_fsm (
      .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .turn_on_request(req), .supply_uvlo(c[0]), .supply_ovlo(c[1]),
      .supply_low_fall_limit(c[2]), .pos_feedback_over_limit(c[3]),
      .neg_feedback_over_limit(c[4]), .pos_failsafe_limit(c[5]), .neg_failsafe_limit(c[6]),
      .pri_overtemp(c[7]), .sec_overtemp(c[8]), .pos_fb_low(c[9]), .neg_fb_low(c[10]),
      .pos_rail_start_level(c[11]), .inverter_peak_limit(c[12]), .inverter_blank_end(c[13]),
      .inverter_blank_over(c[14]), .cfg_auto_restart(cfg_ar), .cfg_good_active_low(cfg_al),
      .output_good_flag_i(pad), .output_good_flag_o(g_o), .output_good_flag_oe(g_oe),
      .primary_switch_en(pri_en), .buckboost_switch_en(bb_en), .primary_duty(duty),
      .mode_code(mode));
   cpm_host_model i_cpm_host_model (.drive_en(drv_en), .drive_val(drv_val), .good_o(g_o),
      .good_oe(g_oe), .turn_on_request(req), .good_pad(pad));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         fails++;
         end_sim();
      end
   endtask
   task automatic wait_mode(input logic [2:0] m, input int lim);
      int n;
      n = 0;
      while (mode !== m && n < lim) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      cmp({29'h0, mode}, {29'h0, m});
      if (mode !== m) begin
         end_sim();
      end
   endtask
   task automatic wait_bb_off(input int lim);
      int n;
      n = 0;
      while (bb_en !== 1'b0 && n < lim) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      cmp({31'h0, bb_en}, 32'h0);
      if (bb_en !== 1'b0) begin
         end_sim();
      end
   endtask
   task automatic setc(input logic [14:0] v);
      @(posedge core_clk);
      c <= v;
   endtask
   task automatic en(input logic de, input logic dv);
      @(posedge core_clk);
      drv_en <= de;
      drv_val <= dv;
   endtask
   task automatic rst(input logic ar, input logic al);
      @(posedge core_clk);
      reset_n <= 1'b0;
      cfg_ar <= ar;
      cfg_al <= al;
      repeat (10) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   initial begin
      fails = 0;
      checks = 0;
      {reset_n, psel, penable, pwrite, drv_val, cfg_ar, cfg_al} = 7'h00;
      drv_en = 1'b1;
      paddr = 12'h000;
      pwdata = 32'h0;
      c = 15'h0000;
      rst(1'b0, 1'b0);
      apb(1'b0, `CPM_OFS_CTRL, 32'h0);
      cmp(rd, `CPM_CTRL_RESET);
      apb(1'b0, 12'h010, 32'h0);
      cmp({31'h0, err}, 32'h1);
      cmp({31'h0, pad}, 32'h0);
      en(1'b1, 1'b1);
      wait_mode(3'h1, 10);
      repeat (20) @(posedge core_clk);
      apb(1'b0, `CPM_OFS_DUTY, 32'h0);
      cmp({31'h0, (rd > 32'h0) && (rd < 32'hFF)}, 32'h1);
      wait_mode(3'h2, 400);
      cmp({31'h0, pad}, 32'h1);
      setc(C_BOVER);
      setc(C_BOVER | C_BEND | C_START);
      repeat (70) @(posedge core_clk);
      cmp({31'h0, bb_en}, 32'h1);
      setc(C_FBOV);
      wait_mode(3'h4, 10);
      cmp({31'h0, pad}, 32'h0);
      apb(1'b0, `CPM_OFS_FAULTS, 32'h0);
      cmp({31'h0, rd[`CPM_FLT_FB_OV]}, 32'h1);
      setc(C_OV);
      repeat (10) @(posedge core_clk);
      cmp({29'h0, mode}, 32'h4);
      setc(15'h0000);
      en(1'b0, 1'b0);
      wait_mode(3'h0, 10);
      en(1'b1, 1'b1);
      wait_mode(3'h2, 400);
      setc(C_UV);
      wait_mode(3'h3, 10);
      setc(15'h0000);
      wait_mode(3'h1, 10);
      setc(C_FS);
      wait_mode(3'h4, 10);
      setc(C_UV | C_LF);
      wait_mode(3'h3, 10);
      setc(15'h0000);
      wait_mode(3'h1, 10);
      setc(C_START);
      repeat (50) @(posedge core_clk);
      cmp({31'h0, bb_en}, 32'h1);
      wait_bb_off(20);
      cmp({31'h0, pri_en}, 32'h1);
      wait_mode(3'h4, 400);
      apb(1'b0, `CPM_OFS_STATUS, 32'h0);
      cmp({31'h0, rd[`CPM_ST_OPEN]}, 32'h1);
      en(1'b0, 1'b0);
      setc(15'h0000);
      wait_mode(3'h0, 10);
      en(1'b1, 1'b1);
      wait_mode(3'h1, 10);
      setc(C_BOVER);
      setc(C_BOVER | C_BEND);
      wait_bb_off(10);
      wait_mode(3'h4, 400);
      apb(1'b0, `CPM_OFS_STATUS, 32'h0);
      cmp({31'h0, rd[`CPM_ST_SHORT]}, 32'h1);
      en(1'b0, 1'b0);
      setc(C_UVFB);
      wait_mode(3'h0, 10);
      en(1'b1, 1'b1);
      wait_mode(3'h1, 10);
      repeat (100) @(posedge core_clk);
      cmp({29'h0, mode}, 32'h1);
      wait_mode(3'h4, 400);
      apb(1'b0, `CPM_OFS_FAULTS, 32'h0);
      cmp({31'h0, rd[`CPM_FLT_UNDERV]}, 32'h1);
      setc(15'h0000);
      apb(1'b1, `CPM_OFS_FAULTS, 32'hFFFF_FFFF);
      apb(1'b0, `CPM_OFS_FAULTS, 32'h0);
      cmp(rd, 32'h0);
      rst(1'b1, 1'b1);
      wait_mode(3'h2, 400);
      cmp({31'h0, pad}, 32'h0);
      apb(1'b0, `CPM_OFS_STATUS, 32'h0);
      cmp({30'h0, rd[`CPM_ST_ACTLOW:`CPM_ST_AUTORST]}, 32'h3);
      setc(C_OT);
      wait_mode(3'h5, 10);
      cmp({31'h0, pad}, 32'h1);
      wait_mode(3'h1, 80);
      setc(C_OT2);
      wait_mode(3'h5, 20);
      wait_mode(3'h1, 80);
      setc(15'h0000);
      wait_mode(3'h2, 400);
      apb(1'b1, `CPM_OFS_CTRL, 32'h1);
      wait_mode(3'h0, 10);
      apb(1'b0, `CPM_OFS_CTRL, 32'h0);
      cmp(rd, 32'h1);
      end_sim();
   end
endmodule
bind cpm_protect_fsm cpm_protect_checker #(.RESTART_CYC(RESTART_CYC)) i_cpm_protect_checker (
   .core_clk, .reset_n, .psel, .penable, .paddr, .pready, .pslverr, .turn_on_request,
   .supply_low_fall_limit, .pos_feedback_over_limit, .neg_feedback_over_limit,
   .pos_failsafe_limit, .neg_failsafe_limit, .pri_overtemp, .sec_overtemp,
   .cfg_good_active_low, .output_good_flag_oe, .primary_switch_en, .buckboost_switch_en,
   .primary_duty, .mode_code);
`default_nettype wire
